// ==== status_event_defines.vh ====
// constants for the status and event reporting block
`ifndef STATUS_EVENT_DEFINES_VH
`define STATUS_EVENT_DEFINES_VH

// event latch register bit positions
`define EVT_OPC_BIT 0
`define EVT_QYE_BIT 2
`define EVT_DDE_BIT 3
`define EVT_EXE_BIT 4
`define EVT_CME_BIT 5
`define EVT_PON_BIT 7
// bits of the event latch register that exist
`define EVT_USED_MASK 8'hBD

// summary status byte bit positions
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_MSS_BIT 6
// summary bits that feed master summary (1 to 5 and 7)
`define STB_SUM_MASK 8'hBE
// service mask bits that can be stored (bit 6 never)
`define SRM_WRITE_MASK 8'hBF

// reset values
`define EVT_RESET 8'h80
`define MASK_RESET 8'h00

// register select codes for reads
`define SEL_STB 2'h0
`define SEL_SRM 2'h1
`define SEL_EVT 2'h2
`define SEL_EEM 2'h3

// largest legal mask write value
`define MASK_MAX 16'h00FF

`endif

// ==== status_mask_reg.v ====
// mask register with range check, shared by both enable masks
`include "status_event_defines.vh"

module status_mask_reg #(
    parameter [7:0] KEEP_MASK = 8'hFF
) (
    // clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // write port
    input wire wr_in,
    input wire [15:0] value_in,
    // state
    output wire [7:0] mask_out,
    output wire range_err_out
);

    reg [7:0] mask_ff;
    reg range_err_ff;
    wire in_range;

    assign in_range = (value_in <= `MASK_MAX);
    assign mask_out = mask_ff;
    assign range_err_out = range_err_ff;

    // store legal values, flag others as execution errors
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            mask_ff <= `MASK_RESET;
            range_err_ff <= 1'b0;
        end else begin
            range_err_ff <= wr_in & ~in_range; // R19
            if (wr_in && in_range) begin
                mask_ff <= value_in[7:0] & KEEP_MASK; // R19
            end
        end
    end

endmodule

// ==== status_event_reporting.v ====
// status byte, event latch register and enable masks for the remote link
//
// Summary of operation
// [R1] event bits latch at 1 until the event register is read or cleared
// [R2] event enable mask gates each event bit into the summary
// [R3] event summary (status bit 5) sets on enabled event rising 0 to 1
// [R4] event summary clears on event register query or clear status
// [R5] events: 0 complete, 2 query, 3 device, 4 execution, 5 command, 7 power
// [R6] operation complete sets when earlier commands finished and link ready
// [R7] query error on empty read, unread response, or both buffers full
// [R8] device error on bad calibration input or input buffer overflow
// [R9] execution error when command parsed but cannot be carried out
// [R10] command error when command is not understood
// [R11] power-on event set after power cycle, here at reset
// [R12] message available sets on response queued, clears on terminator sent
// [R13] status bit 6 is OR of enabled status bits 1 to 5 and 7
// [R14] request service sets on front panel or master summary, poll clears
// [R15] status byte query leaves byte unchanged, bit 6 is master summary
// [R16] reads return the register's 8-bit binary value
// [R17] status byte is eight bits, bits 0 to 3 and 7 read 0
// [R18] event register query returns contents then clears all bits
// [R19] mask writes over 255 raise execution error, service bit 6 ignored
// [R20] clear status clears events; message available only if first message
// [R21] events are one-cycle pulses; set beats simultaneous clear
//
// timing at the ports
// - every request input is taken on a rising edge with reset released
// - event pulses land in the event latch on the edge that takes them
// - event summary follows on that same edge, status output one edge later
// - a mask write over range raises the execution bit one edge after the edge that takes it
// - read and poll answers appear one edge after the request
// - read and poll data hold until the next read or poll
// - valid outputs stand for exactly one cycle
// - status byte output is a continuous level, one edge behind the flags
// - request service output is one edge behind the internal flag
//
// ordering hazards
// - event register query answers the old contents and clears on one edge
// - an event pulse in the clearing cycle survives the clear
// - summary rise is judged against the value left after any clear
// - a queued response beats a terminator or a clear in one cycle
// - request service set beats a simultaneous serial poll
// - while master summary stays high a poll cannot clear request service
//
// limitations
// - power-on event comes from reset, there is no separate power monitor
// - upper write bits only feed the range check, never the stored mask
// - clear status leaves message available unless it opens the line
// - read select codes are local to this block
`include "status_event_defines.vh"

module status_event_reporting (
    // clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // event pulses from parser and output logic
    input wire ops_done_in,
    input wire read_empty_in,
    input wire unread_response_in,
    input wire buffers_full_in,
    input wire cal_input_err_in,
    input wire input_overflow_in,
    input wire exec_fail_in,
    input wire syntax_err_in,
    // output buffer events
    input wire response_queued_in,
    input wire terminator_sent_in,
    // commands
    input wire clear_status_command_in,
    input wire first_message_in,
    input wire event_mask_write_command_in,
    input wire service_mask_write_command_in,
    input wire [15:0] write_value_in,
    input wire read_in,
    input wire [1:0] read_sel_in,
    input wire serial_poll_in,
    input wire front_panel_request_in,
    // read answer
    output reg [7:0] read_data_out,
    output reg read_valid_out,
    output reg [7:0] poll_data_out,
    output reg poll_valid_out,
    // status
    output reg request_service_flag_out,
    output reg [7:0] summary_status_byte_out
);

    reg [7:0] event_latch_register_ff;
    reg event_summary_flag_ff;
    reg message_available_flag_ff;
    reg request_service_flag_ff;
    wire [7:0] nxt_events;
    wire [7:0] evt_rise;
    reg [7:0] set_vec;
    reg nxt_summary;
    reg [7:0] status_byte;
    wire [7:0] event_enable_mask;
    wire [7:0] service_request_mask;
    wire eem_range_err;
    wire srm_range_err;
    wire evt_clear;
    wire master_summary_flag;
    wire [7:0] read_mux;

    // positions of the event latch that exist
    localparam [7:0] USED_BITS = `EVT_USED_MASK;

    // event enable mask
    status_mask_reg #(
        .KEEP_MASK(8'hFF)
    ) u_event_mask (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(event_mask_write_command_in),
        .value_in(write_value_in),
        .mask_out(event_enable_mask),
        .range_err_out(eem_range_err)
    );

    // service request mask, bit 6 dropped
    status_mask_reg #(
        .KEEP_MASK(`SRM_WRITE_MASK)
    ) u_service_mask (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(service_mask_write_command_in),
        .value_in(write_value_in),
        .mask_out(service_request_mask),
        .range_err_out(srm_range_err)
    );

    // event register query or clear status empties the latch
    assign evt_clear = clear_status_command_in |
        (read_in && sel_hit(read_sel_in, `SEL_EVT)); // R18 R20

    // true when a read select code names the given register
    function sel_hit;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_hit = (sel == code);
        end
    endfunction

    // one-cycle event pulses onto their bit positions
    always @* begin
        set_vec = 8'h00;
        set_vec[`EVT_OPC_BIT] = ops_done_in; // R6
        set_vec[`EVT_QYE_BIT] = read_empty_in | unread_response_in | buffers_full_in; // R7
        set_vec[`EVT_DDE_BIT] = cal_input_err_in | input_overflow_in; // R8
        set_vec[`EVT_EXE_BIT] = exec_fail_in | eem_range_err | srm_range_err; // R9 R19
        set_vec[`EVT_CME_BIT] = syntax_err_in; // R10
    end

    // per event bit: value kept past any clear, then the new set
    genvar bi;
    generate
        for (bi = 0; bi < 8; bi = bi + 1) begin : g_event_bit
            wire kept;
            // old value, dropped by a query or clear status
            assign kept = event_latch_register_ff[bi] & ~evt_clear; // R1 R4
            // a set in the clearing cycle survives, unused bits stay 0
            assign nxt_events[bi] = USED_BITS[bi] & (kept | set_vec[bi]); // R5 R21
            // enabled rise from 0, judged after the clear
            assign evt_rise[bi] = set_vec[bi] & ~kept & event_enable_mask[bi]; // R2 R3
        end
    endgenerate

    // summary sets on enabled 0 to 1 edges, clears with the latch
    always @* begin
        if (|evt_rise) begin
            nxt_summary = 1'b1; // R2 R3 R21
        end else if (evt_clear) begin
            nxt_summary = 1'b0; // R4
        end else begin
            nxt_summary = event_summary_flag_ff;
        end
    end

    // status byte with master summary in bit 6
    assign master_summary_flag = |(status_byte_base(message_available_flag_ff,
        event_summary_flag_ff) & service_request_mask & `STB_SUM_MASK); // R13

    always @* begin
        status_byte = status_byte_base(message_available_flag_ff, event_summary_flag_ff);
        status_byte[`STB_MSS_BIT] = master_summary_flag; // R15 R17
    end

    // build the defined bits of the status byte, others zero
    function [7:0] status_byte_base;
        input message_available_flag;
        input event_summary_flag;
        begin
            status_byte_base = 8'h00; // R17
            status_byte_base[`STB_MAV_BIT] = message_available_flag;
            status_byte_base[`STB_ESB_BIT] = event_summary_flag;
        end
    endfunction

    // read selection, returned as plain binary
    assign read_mux = sel_hit(read_sel_in, `SEL_STB) ? status_byte :
        sel_hit(read_sel_in, `SEL_SRM) ? service_request_mask :
        sel_hit(read_sel_in, `SEL_EVT) ? event_latch_register_ff :
        event_enable_mask; // R16

    // event latch and summary; power-on bit raised by reset
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            event_latch_register_ff <= `EVT_RESET; // R11
            event_summary_flag_ff <= 1'b0;
        end else begin
            event_latch_register_ff <= nxt_events;
            event_summary_flag_ff <= nxt_summary;
        end
    end

    // message available; queued response wins over terminator or clear
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            message_available_flag_ff <= 1'b0;
        end else if (response_queued_in) begin
            message_available_flag_ff <= 1'b1; // R12 R21
        end else if (terminator_sent_in || (clear_status_command_in && first_message_in)) begin
            message_available_flag_ff <= 1'b0; // R12 R20
        end
    end

    // request service; set wins over a simultaneous poll
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            request_service_flag_ff <= 1'b0;
        end else if (front_panel_request_in || master_summary_flag) begin
            request_service_flag_ff <= 1'b1; // R14 R21
        end else if (serial_poll_in) begin
            request_service_flag_ff <= 1'b0; // R14
        end
    end

    // register read answer
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            read_data_out <= 8'h00;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= read_in;
            if (read_in) begin
                read_data_out <= read_mux; // R15 R18
            end
        end
    end

    // serial poll answer, bit 6 carries request service
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            poll_data_out <= 8'h00;
            poll_valid_out <= 1'b0;
        end else begin
            poll_valid_out <= serial_poll_in;
            if (serial_poll_in) begin
                poll_data_out <= {status_byte[7], request_service_flag_ff,
                    status_byte[5:0]}; // R14
            end
        end
    end

    // continuous status outputs
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            request_service_flag_out <= 1'b0;
            summary_status_byte_out <= 8'h00;
        end else begin
            request_service_flag_out <= request_service_flag_ff;
            summary_status_byte_out <= status_byte;
        end
    end

endmodule

// ==== status_event_reporting_sva.sv ====
// port checks for the status and event reporting block
module status_event_reporting_sva (
    // clock, reset and requests
    input logic core_clk_in, reset_n_in, read_in, serial_poll_in, clear_status_command_in,
    input logic [1:0] read_sel_in,
    // event pulses and mask writes
    input logic ops_done_in, read_empty_in, unread_response_in, buffers_full_in,
    input logic cal_input_err_in, input_overflow_in, exec_fail_in, syntax_err_in,
    input logic response_queued_in, terminator_sent_in,
    input logic event_mask_write_command_in, service_mask_write_command_in,
    // answers and status
    input logic read_valid_out, poll_valid_out, request_service_flag_out,
    input logic [7:0] summary_status_byte_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // any event source or mask write this cycle
    wire any_ev = ops_done_in | read_empty_in | unread_response_in | buffers_full_in |
        cal_input_err_in | input_overflow_in | exec_fail_in | syntax_err_in;
    wire any_wr = event_mask_write_command_in | service_mask_write_command_in;
    // event clear with nothing able to set the summary again
    sequence s_evt_clear;
        (read_in && read_sel_in == 2'h2 || clear_status_command_in) && !any_ev && !any_wr
            && !$past(any_wr) && !$past(any_wr, 2);
    endsequence
    sequence s_mav_drop;
        terminator_sent_in && !response_queued_in;
    endsequence
    a_read_answered: assert property (read_in |=> read_valid_out) else $error("no answer");
    a_no_stray_read: assert property (!read_in |=> !read_valid_out) else $error("stray");
    a_poll_answered: assert property (serial_poll_in |=> poll_valid_out) else $error("poll");
    a_unused_zero: assert property (summary_status_byte_out[3:0] == 4'h0 &&
        !summary_status_byte_out[7]) else $error("unused status bit set");
    a_mav_sets: assert property (response_queued_in |-> ##2 summary_status_byte_out[4])
        else $error("message flag not set");
    a_mav_drops: assert property (s_mav_drop |-> ##2 !summary_status_byte_out[4])
        else $error("message flag not cleared");
    a_esb_clears: assert property (s_evt_clear |-> ##2 !summary_status_byte_out[5])
        else $error("event summary not cleared");
    a_rqs_follows: assert property (summary_status_byte_out[6] |->
        ##[1:2] request_service_flag_out) else $error("request flag missing");
endmodule
bind status_event_reporting status_event_reporting_sva chk_u (.*);

// ==== host_link.sv ====
// host model issuing register queries and serial polls
module host_link (
    input logic core_clk_in,
    output logic rd_out = 1'b0,
    output logic [1:0] sel_out = 2'h0,
    output logic poll_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one query held for one taken edge, select scrambled after
    task rd(input logic [1:0] s);
        @(posedge core_clk_in);
        rd_out <= 1'b1;
        sel_out <= s;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        sel_out <= ~s;
    endtask
    // serial poll of the status byte
    task poll();
        @(posedge core_clk_in);
        poll_out <= 1'b1;
        @(posedge core_clk_in);
        poll_out <= 1'b0;
    endtask
endmodule

// ==== status_event_reporting_tb.sv ====
// self-checking bench for the status and event reporting block
module status_event_reporting_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, first = 1'b0, ewr = 1'b0, swr = 1'b0;
    logic rd_v, pv, request_service_flag, rd, poll;
    logic [1:0] sel;
    logic [7:0] rd_d, pd, stb;
    logic [11:0] pl = 12'h000;
    logic [15:0] wv = 16'h0000;
    logic [31:0] rnd = 32'hDD01D4CD;
    logic [7:0] expq[$];
    int n_mismatch = 0, cmp_count = 0;
    int bm[8] = '{0, 2, 2, 2, 3, 3, 4, 5};
    always #4 clk = ~clk;
    host_link host_u (.core_clk_in(clk), .rd_out(rd), .sel_out(sel), .poll_out(poll));
    status_event_reporting dut_u (.core_clk_in(clk), .reset_n_in(rst_n),
        .ops_done_in(pl[0]), .read_empty_in(pl[1]), .unread_response_in(pl[2]),
        .buffers_full_in(pl[3]), .cal_input_err_in(pl[4]), .input_overflow_in(pl[5]),
        .exec_fail_in(pl[6]), .syntax_err_in(pl[7]), .response_queued_in(pl[8]),
        .terminator_sent_in(pl[9]), .clear_status_command_in(pl[10]),
        .first_message_in(first), .event_mask_write_command_in(ewr),
        .service_mask_write_command_in(swr), .write_value_in(wv), .read_in(rd),
        .read_sel_in(sel), .serial_poll_in(poll), .front_panel_request_in(pl[11]),
        .read_data_out(rd_d), .read_valid_out(rd_v), .poll_data_out(pd),
        .poll_valid_out(pv), .request_service_flag_out(request_service_flag), .summary_status_byte_out(stb));
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one-cycle pulse on source i
    task pulse(input int i);
        @(posedge clk);
        pl <= 12'h001 << i;
        @(posedge clk);
        pl <= 12'h000;
    endtask
    task wr(input logic e, input logic [15:0] v);
        @(posedge clk);
        ewr <= e;
        swr <= !e;
        wv <= v;
        @(posedge clk);
        ewr <= 1'b0;
        swr <= 1'b0;
        wv <= ~v;
    endtask
    task rdx(input logic [1:0] s, input logic [7:0] e);
        expq.push_back(e);
        host_u.rd(s);
    endtask
    task pollx(input logic [7:0] e);
        expq.push_back(e);
        host_u.poll();
    endtask
    task conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // answers compared against the oldest note
    always @(posedge clk) begin
        if (rd_v === 1'b1 || pv === 1'b1)
            chk(rd_v === 1'b1 ? rd_d : pd, expq.size() ? expq.pop_front() : 8'hXX);
    end
    // hang guard
    initial begin
        cyc(5000);
        n_mismatch++;
        conclude();
    end
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        rdx(2'h2, 8'h80);
        rdx(2'h2, 8'h00);
        rdx(2'h0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            rdx(2'h2, 8'h01 << bm[i]);
        end
        $display("event test done");
        rnd = lfsr(rnd);
        wr(1'b1, {8'h00, rnd[7:0]});
        rdx(2'h3, rnd[7:0]);
        wr(1'b0, {8'h00, rnd[15:8]});
        rdx(2'h1, rnd[15:8] & 8'hBF);
        wr(1'b1, 16'h0100);
        rdx(2'h3, rnd[7:0]);
        rdx(2'h2, 8'h10);
        $display("mask test done");
        wr(1'b1, 16'h0010);
        wr(1'b0, 16'h0020);
        pulse(6);
        cyc(4);
        chk(stb, 8'h60);
        cyc(2);
        chk({7'h00, request_service_flag}, 8'h01);
        rdx(2'h0, 8'h60);
        rdx(2'h0, 8'h60);
        pollx(8'h60);
        rdx(2'h2, 8'h10);
        cyc(4);
        chk(stb, 8'h00);
        pollx(8'h40);
        pollx(8'h00);
        pulse(11);
        pollx(8'h40);
        pollx(8'h00);
        $display("summary test done");
        pulse(8);
        cyc(3);
        chk(stb, 8'h10);
        pulse(10);
        cyc(3);
        chk(stb, 8'h10);
        first <= 1'b1;
        pulse(10);
        cyc(3);
        chk(stb, 8'h00);
        first <= 1'b0;
        pulse(8);
        pulse(9);
        cyc(3);
        chk(stb, 8'h00);
        fork
            pulse(6);
            rdx(2'h2, 8'h00);
        join
        rdx(2'h2, 8'h10);
        $display("message test done");
        cyc(4);
        chk(8'(expq.size()), 8'h00);
        conclude();
    end
endmodule
